// ### hdl/elsc_pkg.sv
// Constants and carriers for the link status and statistics block.
// Assumes one 20 MHz clock and a synchronous active-low reset.
// ------------------------------------------------------------------------
// ------------------------------------------------------------------------
package elsc_pkg;

  // ----------------------------------------------------------------------
  // Services and attributes
  // ----------------------------------------------------------------------
  localparam logic [7:0] SVC_GET       = 8'h0E;
  localparam logic [7:0] SVC_SET       = 8'h10;
  localparam logic [7:0] SVC_GET_CLEAR = 8'h4C;
  localparam logic [7:0] ATTR_SPEED    = 8'h01;
  localparam logic [7:0] ATTR_FLAGS    = 8'h02;
  localparam logic [7:0] ATTR_MAC      = 8'h03;
  localparam logic [7:0] ATTR_IF_CNT   = 8'h04;
  localparam logic [7:0] ATTR_MEDIA    = 8'h05;
  localparam logic [7:0] ATTR_CONTROL  = 8'h06;

  // ----------------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] ST_OK          = 8'h00;
  localparam logic [7:0] ST_BAD_ATTR    = 8'h14;
  localparam logic [7:0] ST_NO_SERVICE  = 8'h08;
  localparam logic [7:0] ST_BAD_VALUE   = 8'h09;
  localparam logic [7:0] ST_CONFLICT    = 8'h0C;
  localparam logic [7:0] ST_NOT_SETABLE = 8'h0E;

  // ----------------------------------------------------------------------
  // Fields, speeds, counters
  // ----------------------------------------------------------------------
  localparam int FLG_LINK   = 0;
  localparam int FLG_DUPLEX = 1;
  localparam int FLG_NEG_LO = 2;
  localparam int FLG_RESET  = 5;
  localparam int FLG_FAULT  = 6;
  localparam int CTL_AUTO   = 0;
  localparam int CTL_DUPLEX = 1;
  localparam logic [2:0] NEG_BUSY   = 3'h0;
  localparam logic [2:0] NEG_FAILED = 3'h1;
  localparam logic [2:0] NEG_SPEED  = 3'h2;
  localparam logic [2:0] NEG_OK     = 3'h3;
  localparam logic [2:0] NEG_FORCED = 3'h4;
  localparam logic [15:0] SPEED_10  = 16'h000A;
  localparam logic [15:0] SPEED_100 = 16'h0064;
  localparam logic        RESET_NEEDED   = 1'b0;
  localparam logic        HALF_SUPPORTED = 1'b1;
  localparam logic        FULL_SUPPORTED = 1'b1;
  localparam logic [15:0] CTL_RESET      = 16'h0001;
  localparam logic [15:0] FSPEED_RESET   = 16'h0064;
  localparam int N_CNT   = 23;
  localparam int N_IF    = 11;
  localparam int N_MEDIA = 12;
  localparam int N_MAC   = 6;
  // Counter slots, receive then transmit then media
  localparam int C_IN_OCT = 0;
  localparam int C_OUT_OCT = 6;
  localparam int C_MEDIA  = 11;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       link_up;
    logic       full_duplex;
    logic       speed_100;
    logic       an_done;
    logic       an_speed_ok;
    logic       an_duplex_ok;
    logic       fault;
  } elsc_phy_type;

  typedef struct packed {
    logic [N_CNT-1:0] hit;
    logic [15:0]      rx_octets;
    logic [15:0]      tx_octets;
  } elsc_evt_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  service;
    logic [7:0]  attr;
    logic [4:0]  member;
    logic [15:0] wdata;
  } elsc_req_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  status;
    logic [31:0] data;
  } elsc_rsp_type;

endpackage : elsc_pkg

// ### hdl/elsc_counter_bank.sv
// Bank of 32-bit statistic counters with read-then-clear.
// Assumes event strobes come from logic on the same clock.
`timescale 1ns/100ps
module elsc_counter_bank
(
  input  wire logic                       sys_clk,
  input  wire logic                       reset_n,
  input  wire elsc_pkg::elsc_evt_type     evt,
  input  wire logic                       clr_en,
  input  wire logic [4:0]                 clr_idx,
  output logic [elsc_pkg::N_CNT-1:0][31:0] counts
);

  typedef struct packed {
    logic [elsc_pkg::N_CNT-1:0][31:0] cnt;
  } elsc_bank_type;

  elsc_bank_type state_r;
  elsc_bank_type state_nxt;

  // Wraps past the top, never saturates
  function automatic logic [31:0] elsc_bump(input logic [31:0] base,
                                            input logic [15:0] amount);
    elsc_bump = base + {16'h0000, amount};
  endfunction : elsc_bump

  always_comb
  begin
    logic [31:0] base;
    logic [15:0] amt;
    base      = 32'h0000_0000;
    amt       = 16'h0000;
    state_nxt = state_r;
    for (int i = 0; i < elsc_pkg::N_CNT; i++)
    begin
      // A cleared slot restarts from zero, so a same-cycle event survives
      base = (clr_en && clr_idx == 5'(i)) ? 32'h0000_0000
                                          : state_r.cnt[i];
      if (i == elsc_pkg::C_IN_OCT)
        amt = evt.rx_octets;
      else if (i == elsc_pkg::C_OUT_OCT)
        amt = evt.tx_octets;
      else
        amt = 16'h0001;
      state_nxt.cnt[i] = evt.hit[i] ? elsc_bump(base, amt)
                                    : base;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign counts = state_r.cnt;

endmodule : elsc_counter_bank

// ### hdl/elsc_top.sv
// Link status, control and statistics for one twisted-pair port.
// Assumes attribute requests and event strobes are on sys_clk, and
// PHY status pins arrive asynchronously.
`timescale 1ns/100ps
module elsc_top
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire elsc_pkg::elsc_phy_type phy_pins,
  input  wire logic [47:0]            mac_addr,
  input  wire elsc_pkg::elsc_evt_type evt,
  input  wire elsc_pkg::elsc_req_type req,
  output elsc_pkg::elsc_rsp_type      rsp,
  output logic                        cfg_auto_neg,
  output logic                        cfg_full_duplex,
  output logic                        cfg_speed_100
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ELSC_IDLE  = 2'b01,
    ELSC_REPLY = 2'b10
  } elsc_phase_type;

  typedef struct packed {
    elsc_pkg::elsc_phy_type sync1;
    elsc_pkg::elsc_phy_type sync2;
    logic [15:0]            ctl;
    logic [15:0]            fspeed;
    elsc_phase_type         phase;
    logic [7:0]             status;
    logic [31:0]            data;
  } elsc_state_type;

  elsc_state_type state_r;
  elsc_state_type state_nxt;

  logic [elsc_pkg::N_CNT-1:0][31:0] counts;
  logic                             clr_en;
  logic [4:0]                       clr_idx;
  logic [2:0]                       neg_code;
  logic                             eff_duplex;
  logic [15:0]                      eff_speed;
  logic [31:0]                      flags;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic elsc_is_counter(input logic [7:0] attr);
    elsc_is_counter = (attr == elsc_pkg::ATTR_IF_CNT) ||
                      (attr == elsc_pkg::ATTR_MEDIA);
  endfunction : elsc_is_counter

  function automatic logic elsc_member_ok(input logic [7:0] attr,
                                          input logic [4:0] member);
    case (attr)
      elsc_pkg::ATTR_IF_CNT:
        elsc_member_ok = member < 5'(elsc_pkg::N_IF);
      elsc_pkg::ATTR_MEDIA:
        elsc_member_ok = member < 5'(elsc_pkg::N_MEDIA);
      elsc_pkg::ATTR_MAC:
        elsc_member_ok = member < 5'(elsc_pkg::N_MAC);
      elsc_pkg::ATTR_CONTROL:
        elsc_member_ok = member < 5'h02;
      default:
        elsc_member_ok = member == 5'h00;
    endcase
  endfunction : elsc_member_ok

  function automatic logic [4:0] elsc_slot(input logic [7:0] attr,
                                           input logic [4:0] member);
    elsc_slot = (attr == elsc_pkg::ATTR_MEDIA)
              ? member + 5'(elsc_pkg::C_MEDIA) : member;
  endfunction : elsc_slot

  // ----------------------------------------------------------------------
  // Link state as seen after synchronising the PHY pins
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (!state_r.ctl[elsc_pkg::CTL_AUTO])
    begin
      neg_code   = elsc_pkg::NEG_FORCED;
      eff_duplex = state_r.ctl[elsc_pkg::CTL_DUPLEX];
      eff_speed  = state_r.fspeed;
    end
    else if (!state_r.sync2.an_done)
    begin
      neg_code   = elsc_pkg::NEG_BUSY;
      eff_duplex = 1'b0;
      eff_speed  = elsc_pkg::SPEED_10;
    end
    else if (!state_r.sync2.an_speed_ok)
    begin
      // Nothing learned from the partner: safest common setting
      neg_code   = elsc_pkg::NEG_FAILED;
      eff_duplex = 1'b0;
      eff_speed  = elsc_pkg::SPEED_10;
    end
    else
    begin
      neg_code   = state_r.sync2.an_duplex_ok ? elsc_pkg::NEG_OK
                                              : elsc_pkg::NEG_SPEED;
      eff_duplex = state_r.sync2.an_duplex_ok &&
                   state_r.sync2.full_duplex;
      eff_speed  = state_r.sync2.speed_100 ? elsc_pkg::SPEED_100
                                           : elsc_pkg::SPEED_10;
    end
  end

  always_comb
  begin
    flags                        = 32'h0000_0000;
    flags[elsc_pkg::FLG_LINK]    = state_r.sync2.link_up;
    // Duplex is driven even with link down; readers must ignore it
    flags[elsc_pkg::FLG_DUPLEX]  = eff_duplex;
    flags[elsc_pkg::FLG_NEG_LO +: 3] = neg_code;
    flags[elsc_pkg::FLG_RESET]   = elsc_pkg::RESET_NEEDED;
    flags[elsc_pkg::FLG_FAULT]   = state_r.sync2.fault;
  end

  // ----------------------------------------------------------------------
  // Request handling
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [4:0]  slot;
    logic        hit_ok;
    logic [15:0] wd;
    slot      = elsc_slot(req.attr, req.member);
    hit_ok    = elsc_member_ok(req.attr, req.member);
    wd        = req.wdata;
    state_nxt = state_r;
    clr_en    = 1'b0;
    clr_idx   = slot;

    state_nxt.sync1 = phy_pins;
    state_nxt.sync2 = state_r.sync1;

    state_nxt.phase  = ELSC_IDLE;
    state_nxt.status = elsc_pkg::ST_OK;
    state_nxt.data   = 32'h0000_0000;

    if (req.valid)
    begin
      state_nxt.phase = ELSC_REPLY;
      if (!hit_ok)
        state_nxt.status = elsc_pkg::ST_BAD_ATTR;
      else
      begin
        case (req.service)
          elsc_pkg::SVC_GET,
          elsc_pkg::SVC_GET_CLEAR:
          begin
            case (req.attr)
              elsc_pkg::ATTR_SPEED:
                state_nxt.data = {16'h0000, eff_speed};
              elsc_pkg::ATTR_FLAGS:
                state_nxt.data = flags;
              elsc_pkg::ATTR_MAC:
                // Element 0 is the first octet sent on the wire
                state_nxt.data = {24'h00_0000,
                                  mac_addr[(5 - req.member[2:0]) * 8 +: 8]};
              elsc_pkg::ATTR_IF_CNT,
              elsc_pkg::ATTR_MEDIA:
                state_nxt.data = counts[slot];
              elsc_pkg::ATTR_CONTROL:
                state_nxt.data = {16'h0000, req.member[0] ? state_r.fspeed
                                                          : state_r.ctl};
              default:
                state_nxt.status = elsc_pkg::ST_BAD_ATTR;
            endcase
            // Old value goes out while the slot restarts from zero
            if (req.service == elsc_pkg::SVC_GET_CLEAR)
            begin
              if (elsc_is_counter(req.attr))
                clr_en = 1'b1;
              else
                state_nxt.status = elsc_pkg::ST_NO_SERVICE;
            end
          end
          elsc_pkg::SVC_SET:
          begin
            if (req.attr != elsc_pkg::ATTR_CONTROL)
              state_nxt.status = elsc_pkg::ST_NOT_SETABLE;
            else if (req.member[0])
            begin
              if (wd == elsc_pkg::SPEED_10 || wd == elsc_pkg::SPEED_100)
                state_nxt.fspeed = wd;
              else
                state_nxt.status = elsc_pkg::ST_BAD_VALUE;
            end
            else if (wd[15:2] != 14'h0000)
              state_nxt.status = elsc_pkg::ST_BAD_VALUE;
            else if (wd[elsc_pkg::CTL_AUTO] && wd[elsc_pkg::CTL_DUPLEX])
              state_nxt.status = elsc_pkg::ST_CONFLICT;
            else if (!wd[elsc_pkg::CTL_AUTO] &&
                     (wd[elsc_pkg::CTL_DUPLEX] ? !elsc_pkg::FULL_SUPPORTED
                                               : !elsc_pkg::HALF_SUPPORTED))
              state_nxt.status = elsc_pkg::ST_BAD_VALUE;
            else
              state_nxt.ctl = wd;
          end
          default:
            state_nxt.status = elsc_pkg::ST_NO_SERVICE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_r        <= '0;
      state_r.ctl    <= elsc_pkg::CTL_RESET;
      state_r.fspeed <= elsc_pkg::FSPEED_RESET;
      state_r.phase  <= ELSC_IDLE;
    end
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------------
  // Counters and outputs
  // ----------------------------------------------------------------------
  elsc_counter_bank u_bank
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .evt     (evt),
    .clr_en  (clr_en),
    .clr_idx (clr_idx),
    .counts  (counts)
  );

  always_comb
  begin
    rsp.valid = state_r.phase == ELSC_REPLY;
    case (state_r.phase)
      ELSC_REPLY:
      begin
        rsp.status = state_r.status;
        rsp.data   = state_r.data;
      end
      default:
      begin
        rsp.status = elsc_pkg::ST_OK;
        rsp.data   = 32'h0000_0000;
      end
    endcase
  end

  assign cfg_auto_neg    = state_r.ctl[elsc_pkg::CTL_AUTO];
  assign cfg_full_duplex = state_r.ctl[elsc_pkg::CTL_DUPLEX];
  assign cfg_speed_100   = state_r.fspeed == elsc_pkg::SPEED_100;

endmodule : elsc_top

// ### verification/elsc_link_partner.sv
// Far-end link model: line status pins and traffic event strobes.
// Assumes the bench steers it just after the rising clock edge.
`timescale 1ns/100ps
module elsc_link_partner
(
  input  wire logic             sys_clk,
  input  wire logic [2:0]       mode,
  input  wire logic             fault,
  input  wire logic             fire,
  input  wire logic [4:0]       slot,
  input  wire logic [15:0]      amount,
  output elsc_pkg::elsc_phy_type phy_pins,
  output elsc_pkg::elsc_evt_type evt
);
  // ----------------------------------------
  // Line status by negotiation outcome
  // ----------------------------------------
  // Speed and duplex pins rise even when negotiation fails,
  // so a fallback that trusts the pins shows up.
  always_comb
  begin
    phy_pins              = '0;
    phy_pins.link_up      = mode != 3'h0;
    phy_pins.an_done      = mode >= 3'h2;
    phy_pins.an_speed_ok  = mode >= 3'h3;
    phy_pins.an_duplex_ok = mode == 3'h4;
    phy_pins.speed_100    = mode >= 3'h2;
    phy_pins.full_duplex  = mode >= 3'h2;
    phy_pins.fault        = fault;
  end

  // ----------------------------------------
  // One-cycle event strobes
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    evt.hit       <= fire ? (23'h000001 << slot) : 23'h000000;
    evt.rx_octets <= amount;
    evt.tx_octets <= amount;
  end
endmodule : elsc_link_partner

// ### verification/elsc_assertions.sv
// Port checks for the link status and statistics block.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/100ps
module elsc_assertions
(
  input wire logic                   sys_clk,
  input wire logic                   reset_n,
  input wire elsc_pkg::elsc_phy_type phy_pins,
  input wire logic [47:0]            mac_addr,
  input wire elsc_pkg::elsc_evt_type evt,
  input wire elsc_pkg::elsc_req_type req,
  input wire elsc_pkg::elsc_rsp_type rsp,
  input wire logic                   cfg_auto_neg,
  input wire logic                   cfg_full_duplex,
  input wire logic                   cfg_speed_100
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  elsc_pkg::elsc_req_type prev_r;
  logic [9:0]             look_r;
  logic [3:0]             stab_r;
  logic [9:0]             look;
  logic                   flg_rd;
  logic                   ctl_wr;

  assign look = {phy_pins, cfg_auto_neg, cfg_full_duplex, cfg_speed_100};
  assign flg_rd = rsp.valid && prev_r.service == elsc_pkg::SVC_GET
                  && prev_r.attr == elsc_pkg::ATTR_FLAGS;
  assign ctl_wr = req.valid && req.service == elsc_pkg::SVC_SET
                  && req.attr == elsc_pkg::ATTR_CONTROL && req.member == 5'h00;

  // Pins cross two flops, so pin-dependent flags are judged only once settled; fixed bits always
  always_ff @(posedge sys_clk)
  begin
    prev_r <= req;
    look_r <= look;
    if (!reset_n || look_r != look)
      stab_r <= 4'h0;
    else if (stab_r != 4'hF)
      stab_r <= stab_r + 4'h1;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_answer_next: assert property (
    req.valid |=> rsp.valid) else $error("no answer after request");
  a_speed_legal: assert property (
    rsp.valid && prev_r.attr == elsc_pkg::ATTR_SPEED
    && prev_r.service == elsc_pkg::SVC_GET && rsp.status == 8'h00
    |-> rsp.data == 32'h0000000A || rsp.data == 32'h00000064)
    else $error("speed neither 10 nor 100");
  a_flags_fixed: assert property (
    flg_rd |-> rsp.data[31:7] == 25'h0 && !rsp.data[5])
    else $error("fixed flag bits not zero");
  a_link_fault: assert property (
    flg_rd && stab_r >= 4'h3 |-> rsp.data[0] == phy_pins.link_up
    && rsp.data[6] == phy_pins.fault) else $error("link or fault flag");
  a_forced_code: assert property (
    flg_rd && stab_r >= 4'h3 && !cfg_auto_neg
    |-> rsp.data[4:2] == elsc_pkg::NEG_FORCED
    && (!phy_pins.link_up || rsp.data[1] == cfg_full_duplex))
    else $error("forced outcome flags wrong");
  a_fallback: assert property (
    flg_rd && stab_r >= 4'h3 && cfg_auto_neg && phy_pins.an_done
    && !phy_pins.an_speed_ok |-> rsp.data[4:2] == elsc_pkg::NEG_FAILED
    && !rsp.data[1]) else $error("failed negotiation not half duplex");
  a_conflict_code: assert property (
    ctl_wr && req.wdata[15:2] == 14'h0 && &req.wdata[1:0]
    |=> rsp.status == elsc_pkg::ST_CONFLICT && $stable(cfg_auto_neg))
    else $error("duplex with negotiation not refused");
  a_reserved_ctl: assert property (
    ctl_wr && |req.wdata[15:2] |=> rsp.status == elsc_pkg::ST_BAD_VALUE
    && $stable(cfg_full_duplex)) else $error("reserved control accepted");
  a_ctl_applied: assert property (
    ctl_wr && req.wdata[15:2] == 14'h0 && !(&req.wdata[1:0])
    |=> rsp.status == elsc_pkg::ST_OK && cfg_auto_neg == $past(req.wdata[0])
    && cfg_full_duplex == $past(req.wdata[1]))
    else $error("control write not applied");
endmodule : elsc_assertions

bind elsc_top elsc_assertions chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .phy_pins(phy_pins),
  .mac_addr(mac_addr), .evt(evt), .req(req), .rsp(rsp),
  .cfg_auto_neg(cfg_auto_neg), .cfg_full_duplex(cfg_full_duplex),
  .cfg_speed_100(cfg_speed_100));

// ### verification/elsc_top_tb_top.sv
// Self-checking bench for the link status and statistics block.
// Assumes the link partner model and the bound checker are compiled.
`timescale 1ns/100ps
module elsc_top_tb_top;
  logic                   sys_clk;
  logic                   reset_n;
  elsc_pkg::elsc_phy_type phy_pins;
  elsc_pkg::elsc_evt_type evt;
  elsc_pkg::elsc_req_type req;
  elsc_pkg::elsc_rsp_type rsp;
  logic [47:0]            mac_addr;
  logic                   cfg_auto_neg;
  logic                   cfg_full_duplex;
  logic                   cfg_speed_100;
  logic [2:0]             mode;
  logic                   fault;
  logic                   fire;
  logic [4:0]             slot;
  logic [15:0]            amount;
  logic [31:0]            dt;
  logic [31:0]            st;
  int                     n_errors;
  int                     checked;
  localparam logic [31:0] FLG_EXP [5] = '{32'h00, 32'h01, 32'h05, 32'h09,
                                          32'h0F};
  localparam logic [31:0] SPD_EXP [5] = '{32'h0A, 32'h0A, 32'h0A, 32'h64,
                                          32'h64};

  elsc_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .phy_pins(phy_pins),
    .mac_addr(mac_addr), .evt(evt), .req(req), .rsp(rsp),
    .cfg_auto_neg(cfg_auto_neg), .cfg_full_duplex(cfg_full_duplex),
    .cfg_speed_100(cfg_speed_100));
  elsc_link_partner far_end (.sys_clk(sys_clk), .mode(mode), .fault(fault),
    .fire(fire), .slot(slot), .amount(amount), .phy_pins(phy_pins),
    .evt(evt));

  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // Request stays up; callers end a burst with idle
  task automatic xfer(input logic [7:0] s, input logic [7:0] a,
                      input logic [4:0] m, input logic [15:0] w);
    req = {1'b1, s, a, m, w};
    cyc(1);
    chk("answer", {31'h0, rsp.valid}, 32'h1);
    st = {24'h0, rsp.status};
    dt = rsp.data;
  endtask : xfer

  task automatic get(input logic [7:0] a, input logic [4:0] m);
    xfer(elsc_pkg::SVC_GET, a, m, 16'h0000);
  endtask : get

  task automatic idle;
    req.valid = 1'b0;
    cyc(1);
  endtask : idle

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("cfg", {29'h0, cfg_auto_neg, cfg_full_duplex, cfg_speed_100},
        32'h5);
    get(elsc_pkg::ATTR_CONTROL, 5'h00);
    chk("ctl", dt, 32'h1);
    get(elsc_pkg::ATTR_CONTROL, 5'h01);
    chk("fspeed", dt, 32'h64);
    idle();
  endtask : t_reset

  task automatic t_negotiate;
    for (int i = 0; i < 5; i++)
    begin
      mode = 3'(i);
      cyc(3);
      get(elsc_pkg::ATTR_FLAGS, 5'h00);
      // Duplex bit ignored while the link is down
      chk("flags", dt & (i == 0 ? 32'hFFFFFFFD : 32'hFFFFFFFF),
          FLG_EXP[i]);
      get(elsc_pkg::ATTR_SPEED, 5'h00);
      chk("speed", dt, SPD_EXP[i]);
      idle();
    end
    fault = 1'b1;
    cyc(3);
    get(elsc_pkg::ATTR_FLAGS, 5'h00);
    chk("fault", dt, 32'h4F);
    idle();
    fault = 1'b0;
  endtask : t_negotiate

  task automatic t_control;
    logic [15:0] w [6] = '{16'h0004, 16'h0003, 16'h0032, 16'h000A,
                           16'h0002, 16'h0000};
    logic [31:0] e [6] = '{32'h09, 32'h0C, 32'h09, 32'h00, 32'h00, 32'h00};
    for (int i = 0; i < 6; i++)
    begin
      xfer(elsc_pkg::SVC_SET, elsc_pkg::ATTR_CONTROL, 5'((i / 2) % 2), w[i]);
      chk("set", st, e[i]);
      if (i == 1)
      begin
        get(elsc_pkg::ATTR_CONTROL, 5'h00);
        chk("kept", dt, 32'h1);
      end
      if (i == 4)
      begin
        chk("cfg", {30'h0, cfg_auto_neg, cfg_full_duplex}, 32'h1);
        idle();
        cyc(2);
        get(elsc_pkg::ATTR_FLAGS, 5'h00);
        chk("forced", dt, 32'h13);
        get(elsc_pkg::ATTR_SPEED, 5'h00);
        chk("fspd", dt, 32'h0A);
      end
    end
    chk("half", {31'h0, cfg_full_duplex}, 32'h0);
    xfer(elsc_pkg::SVC_SET, elsc_pkg::ATTR_CONTROL, 5'h00, 16'h0001);
    idle();
  endtask : t_control

  task automatic t_counters;
    logic [7:0] a;
    for (int i = 0; i < 23; i++)
    begin
      fire = 1'b1;
      slot = 5'(i);
      amount = 16'h1234;
      cyc(1);
    end
    fire = 1'b0;
    cyc(2);
    for (int i = 0; i < 23; i++)
    begin
      a = i < 11 ? elsc_pkg::ATTR_IF_CNT : elsc_pkg::ATTR_MEDIA;
      xfer(elsc_pkg::SVC_GET_CLEAR, a, 5'(i < 11 ? i : i - 11), 16'h0000);
      chk("st", st, 32'h0);
      chk("count", dt, (i == 0 || i == 6) ? 32'h1234 : 32'h1);
      get(a, 5'(i < 11 ? i : i - 11));
      chk("clear", dt, 32'h0);
    end
    // Event in the clearing cycle must survive the clear
    fire = 1'b1;
    slot = 5'h0C;
    cyc(1);
    fire = 1'b0;
    xfer(elsc_pkg::SVC_GET_CLEAR, elsc_pkg::ATTR_MEDIA, 5'h01, 16'h0000);
    chk("race", dt, 32'h0);
    get(elsc_pkg::ATTR_MEDIA, 5'h01);
    chk("survive", dt, 32'h1);
    idle();
  endtask : t_counters

  task automatic t_mac_refuse;
    for (int m = 0; m < 6; m++)
    begin
      get(elsc_pkg::ATTR_MAC, 5'(m));
      chk("mac", dt, {24'h0, mac_addr[47-8*m -: 8]});
    end
    xfer(elsc_pkg::SVC_SET, elsc_pkg::ATTR_MAC, 5'h00, 16'h00FF);
    chk("ro", st, 32'h0E);
    get(8'h07, 5'h00);
    chk("attr", st, 32'h14);
    get(elsc_pkg::ATTR_IF_CNT, 5'h0B);
    chk("member", st, 32'h14);
    xfer(8'h33, elsc_pkg::ATTR_SPEED, 5'h00, 16'h0000);
    chk("svc", st, 32'h08);
    xfer(elsc_pkg::SVC_GET_CLEAR, elsc_pkg::ATTR_FLAGS, 5'h00, 16'h0000);
    chk("gclr", st, 32'h08);
    idle();
  endtask : t_mac_refuse

  initial
  begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    req = '0;
    mac_addr = 48'h02A55A3CC381; // Arbitrary test address
    mode = 3'h0;
    fault = 1'b0;
    fire = 1'b0;
    slot = 5'h00;
    amount = 16'h0000;
    n_errors = 0;
    checked = 0;
    repeat (5) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_negotiate();
    t_control();
    t_counters();
    t_mac_refuse();
    give_verdict();
  end
endmodule : elsc_top_tb_top
